// ### rtl/dcs_pkg.sv
package dcs_pkg;
    localparam int BIT_REF_LSB   = 0;
    localparam int BIT_REF_MSB   = 1;
    localparam int BIT_DC_BRAKE  = 2;
    localparam int BIT_COAST     = 3;
    localparam int BIT_QSTOP     = 4;
    localparam int BIT_HOLD      = 5;
    localparam int BIT_START     = 6;
    localparam int BIT_RESET     = 7;
    localparam int BIT_JOG       = 8;
    localparam int BIT_RAMP_SEL  = 9;
    localparam int BIT_VALID     = 10;
    localparam int BIT_RELAY1    = 11;
    localparam int BIT_RELAY4    = 12;
    localparam int BIT_SETUP_LSB = 13;
    localparam int BIT_SETUP_MSB = 14;
    localparam int BIT_REVERSE   = 15;
    localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
    localparam logic [15:0] REF_RESET_VAL = 16'h0000;
    localparam logic [15:0] REF_FULL_SCALE = 16'h4000;
    typedef enum logic [1:0] {
        DCS_GATE_DIN,
        DCS_GATE_BUS,
        DCS_GATE_AND,
        DCS_GATE_OR
    } dcs_gate_t;
endpackage

// ### rtl/dcs_gate.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_gate
    import dcs_pkg::*;
(
    input  wire logic [1:0] sel,     // Gating selection
    input  wire logic       bus_bit, // Bus command bit
    input  wire logic       din_bit, // Digital input function
    output logic            y        // Combined result
);
    always_comb begin
        unique case (dcs_gate_t'(sel))
            DCS_GATE_DIN: y = din_bit;
            DCS_GATE_BUS: y = bus_bit;
            DCS_GATE_AND: y = bus_bit & din_bit;
            DCS_GATE_OR:  y = bus_bit | din_bit;
        endcase
    end
endmodule
`default_nettype wire

// ### rtl/dcs_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_ctrl
    import dcs_pkg::*;
(
    input  wire logic        clock,          // 50 MHz clock
    input  wire logic        rst,            // Async reset, high
    input  wire logic        cmd_we,         // Command word write strobe
    input  wire logic [15:0] cmd_wdata,      // drive_command_word
    input  wire logic        ref_we,         // Speed reference write strobe
    input  wire logic [15:0] ref_wdata,      // bus_speed_reference
    input  wire logic [15:0] act_value,      // Actual output, bus scaling
    input  wire logic [1:0]  coast_sel,      // Coast gating selection
    input  wire logic [1:0]  start_sel,      // Start gating selection
    input  wire logic [1:0]  setup_sel,      // Set-up gating selection
    input  wire logic [1:0]  preset_sel,     // Preset gating selection
    input  wire logic [1:0]  reverse_sel,    // Reverse gating selection
    input  wire logic        din_coast_n,    // Input: no coasting
    input  wire logic        din_start,      // Input: start
    input  wire logic [1:0]  din_setup,      // Input: set-up select
    input  wire logic [1:0]  din_preset,     // Input: preset select
    input  wire logic        din_reverse,    // Input: reverse
    input  wire logic        din_stop_req,   // Input DC brake stop request
    input  wire logic        relay1_follow,  // Relay 01 follows bus
    input  wire logic        relay4_follow,  // Relay 04 follows bus
    input  wire logic        multi_setup,    // Multi set-up enabled
    input  wire logic        ctrl_ready,     // Control electronics ready
    input  wire logic        drive_ready,    // Power part ready
    input  wire logic        tripped,        // Trip active
    input  wire logic        err_no_trip,    // Error without trip
    input  wire logic        trip_locked,    // Trip lock
    input  wire logic        warning,        // Any warning
    input  wire logic        on_reference,   // Speed equals reference
    input  wire logic        local_mode,     // Local stop/reset or ref
    input  wire logic        freq_in_limit,  // Within speed limits
    input  wire logic        freq_nonzero,   // Output frequency above 0
    input  wire logic        overtemp_auto,  // Overtemp autorestart stop
    input  wire logic        dc_volt_bad,    // DC link out of range
    input  wire logic        torque_over,    // Torque limit exceeded
    input  wire logic        thermal_over,   // Thermal timer over 100%
    input  wire logic        link_ok,        // Bus option link healthy
    output logic [1:0]       preset_idx,     // Chosen preset reference
    output logic             dc_brake,       // DC brake and stop
    output logic             output_off,     // Output stage off, coast
    output logic             quick_stop,     // Quick-stop ramp down
    output logic             freeze,         // Hold output frequency
    output logic             run_permit,     // Start permitted
    output logic             trip_reset,     // One-cycle trip reset
    output logic             jog,            // Use jog speed
    output logic             ramp2,          // Use second ramp pair
    output logic             relay1,         // Relay 01 drive
    output logic             relay4,         // Relay 04 drive
    output logic [1:0]       setup_idx,      // Active set-up, 0..3
    output logic             reverse,        // Reverse direction
    output logic [15:0]      speed_ref,      // Accepted speed reference
    output logic [15:0]      status_word,    // drive_status_word
    output logic [15:0]      actual_out      // actual_output_value
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] cmd_q;
    logic        rst_bit_q;
    logic        coast_ok;
    logic        start_ok;
    logic [1:0]  setup_g;
    logic [1:0]  preset_g;
    logic        rev_g;
    logic        rev_bus_ok;
    logic        running;
    logic [15:0] stw_d;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_q <= CMD_RESET_VAL;
        end else if (cmd_we && cmd_wdata[BIT_VALID]) begin
            cmd_q <= cmd_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            speed_ref <= REF_RESET_VAL;
        end else if (ref_we) begin
            speed_ref <= ref_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    dcs_gate u_coast (
        .sel     (coast_sel),
        .bus_bit (cmd_q[BIT_COAST]),
        .din_bit (din_coast_n),
        .y       (coast_ok)
    );
    dcs_gate u_start (
        .sel     (start_sel),
        .bus_bit (cmd_q[BIT_START]),
        .din_bit (din_start),
        .y       (start_ok)
    );
    dcs_gate u_rev (
        .sel     (reverse_sel),
        .bus_bit (cmd_q[BIT_REVERSE]),
        .din_bit (din_reverse),
        .y       (rev_g)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sel
            dcs_gate u_setup (
                .sel     (setup_sel),
                .bus_bit (cmd_q[BIT_SETUP_LSB + gi]),
                .din_bit (din_setup[gi]),
                .y       (setup_g[gi])
            );
            dcs_gate u_preset (
                .sel     (preset_sel),
                .bus_bit (cmd_q[BIT_REF_LSB + gi]),
                .din_bit (din_preset[gi]),
                .y       (preset_g[gi])
            );
        end
    endgenerate

    // bus reverse only for bus, and, or sources
    assign rev_bus_ok = (reverse_sel != 2'(DCS_GATE_DIN));
    assign running = coast_ok && start_ok && cmd_q[BIT_DC_BRAKE];

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preset_idx <= 2'h0;
            dc_brake   <= 1'b1;
            output_off <= 1'b1;
            quick_stop <= 1'b1;
            freeze     <= 1'b0;
            run_permit <= 1'b0;
            jog        <= 1'b0;
            ramp2      <= 1'b0;
            relay1     <= 1'b0;
            relay4     <= 1'b0;
            setup_idx  <= 2'h0;
            reverse    <= 1'b0;
        end else begin
            preset_idx <= preset_g;
            dc_brake   <= ~cmd_q[BIT_DC_BRAKE] | din_stop_req;
            output_off <= ~coast_ok;
            quick_stop <= ~cmd_q[BIT_QSTOP];
            freeze     <= ~cmd_q[BIT_HOLD];
            // frozen drive ignores quick stop, but ramp stop still stops it
            run_permit <= running && (~cmd_q[BIT_HOLD] ||
                          (start_ok && cmd_q[BIT_QSTOP])) && ~din_stop_req;
            jog        <= cmd_q[BIT_JOG];
            ramp2      <= cmd_q[BIT_RAMP_SEL];
            relay1     <= relay1_follow & cmd_q[BIT_RELAY1];
            relay4     <= relay4_follow & cmd_q[BIT_RELAY4];
            setup_idx  <= multi_setup ? setup_g : 2'h0;
            reverse    <= rev_bus_ok ? rev_g : din_reverse;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rst_bit_q  <= 1'b0;
            trip_reset <= 1'b0;
        end else begin
            rst_bit_q  <= cmd_q[BIT_RESET];
            trip_reset <= cmd_q[BIT_RESET] & ~rst_bit_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        stw_d = 16'h0000;
        stw_d[0]  = ctrl_ready;
        stw_d[1]  = drive_ready;
        stw_d[2]  = ~output_off;
        stw_d[3]  = tripped;
        stw_d[4]  = err_no_trip;
        stw_d[5]  = 1'b0;
        stw_d[6]  = trip_locked;
        stw_d[7]  = warning;
        stw_d[8]  = on_reference;
        stw_d[9]  = ~local_mode;
        stw_d[10] = freq_in_limit;
        stw_d[11] = run_permit | freq_nonzero;
        stw_d[12] = overtemp_auto;
        stw_d[13] = dc_volt_bad;
        stw_d[14] = torque_over;
        stw_d[15] = thermal_over;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_word <= 16'h0000;
            actual_out  <= 16'h0000;
        end else begin
            status_word <= link_ok ? stw_d : 16'h0000;
            actual_out  <= act_value;
        end
    end
endmodule
`default_nettype wire

// ### sim/dcs_props.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_props (
    input wire logic        clock,       // Clock
    input wire logic        rst,         // Reset
    input wire logic        cmd_we,      // Cmd strobe
    input wire logic [15:0] cmd_wdata,   // Cmd word
    input wire logic        ref_we,      // Ref strobe
    input wire logic [15:0] ref_wdata,   // Ref word
    input wire logic [15:0] act_value,   // Actual in
    input wire logic        link_ok,     // Link state
    input wire logic        din_stop_req, // Input stop request
    input wire logic        dc_brake,    // Brake out
    input wire logic        trip_reset,  // Trip pulse
    input wire logic        jog,         // Jog out
    input wire logic        ramp2,       // Ramp pair
    input wire logic [15:0] speed_ref,   // Ref out
    input wire logic [15:0] status_word, // Status out
    input wire logic [15:0] actual_out   // Actual out
);
    logic acc;
    logic b7_q;
    assign acc = cmd_we && cmd_wdata[10];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // Edge detect needs the last accepted level, not the last write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            b7_q <= 1'b0;
        end else if (acc) begin
            b7_q <= cmd_wdata[7];
        end
    end
    property p_edge; acc && cmd_wdata[7] && !b7_q |-> ##2 trip_reset; endproperty
    a_edge: assert property (p_edge) else $error("trip reset missing");
    property p_level; !(acc && cmd_wdata[7] && !b7_q) |-> ##2 !trip_reset; endproperty
    a_level: assert property (p_level) else $error("trip reset without edge");
    property p_jog; acc |-> ##2 {ramp2, jog} == $past(cmd_wdata[9:8], 2); endproperty
    a_jog: assert property (p_jog) else $error("jog or ramp pair wrong");
    property p_brake;
        acc |-> ##2 dc_brake == (!$past(cmd_wdata[2], 2) || $past(din_stop_req));
    endproperty
    a_brake: assert property (p_brake) else $error("dc brake wrong");
    // An accepted word one cycle earlier has already landed before this window
    property p_hold;
        cmd_we && !cmd_wdata[10] && !$past(acc) && !$past(din_stop_req) && !din_stop_req
            |-> ##2 $stable(jog) && $stable(dc_brake);
    endproperty
    a_hold: assert property (p_hold) else $error("invalid word acted on");
    property p_ref; ref_we |=> speed_ref == $past(ref_wdata); endproperty
    a_ref: assert property (p_ref) else $error("speed reference wrong");
    property p_act; $changed(act_value) |=> actual_out == $past(act_value); endproperty
    a_act: assert property (p_act) else $error("actual value wrong");
    property p_link; !link_ok |=> status_word == 16'h0000; endproperty
    a_link: assert property (p_link) else $error("status not cleared");
endmodule
bind dcs_ctrl dcs_props dcs_props_inst (.*);
`default_nettype wire

// ### sim/dcs_master.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_master (
    input wire logic        clock,     // Clock
    output logic            cmd_we,    // Cmd strobe
    output logic [15:0]     cmd_wdata, // Cmd word
    output logic            ref_we,    // Ref strobe
    output logic [15:0]     ref_wdata  // Ref word
);
    initial begin
        {cmd_we, ref_we, cmd_wdata, ref_wdata} = '0;
    end
    ////////////////////////////////////////////////////////////
    // validity bit rides in the word
    task automatic send_cmd(input logic [15:0] wd, input int gap);
        repeat (gap) @(posedge clock);
        @(posedge clock);
        cmd_we <= 1'b1;
        cmd_wdata <= wd;
        @(posedge clock);
        cmd_we <= 1'b0;
        // Released word is inverted so stale data cannot pass
        cmd_wdata <= ~wd;
    endtask
    // signed percent, 16'h4000 is full scale
    task automatic send_ref(input logic [15:0] rd);
        @(posedge clock);
        ref_we <= 1'b1;
        ref_wdata <= rd;
        @(posedge clock);
        ref_we <= 1'b0;
        ref_wdata <= ~rd;
    endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dcs_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_we, ref_we, din_coast_n, din_start, din_reverse, din_stop_req, tr;
    logic        relay1_follow, relay4_follow, multi_setup, link_ok, ctrl_ready, drive_ready;
    logic        tripped, err_no_trip, trip_locked, warning, on_reference, local_mode;
    logic        freq_in_limit, freq_nonzero, overtemp_auto, dc_volt_bad, torque_over;
    logic        thermal_over, dc_brake, output_off, quick_stop, freeze, run_permit;
    logic        trip_reset, jog, ramp2, relay1, relay4, reverse;
    logic [1:0]  coast_sel, start_sel, setup_sel, preset_sel, reverse_sel;
    logic [1:0]  din_setup, din_preset, preset_idx, setup_idx;
    logic [15:0] cmd_wdata, ref_wdata, act_value, speed_ref, status_word, actual_out;
    logic [15:0] cw, w, r, e;
    logic        cg, sg, rp;
    int          errors = 0, num_checks = 0, cyc = 0;

    dcs_ctrl dcs_ctrl_inst (.*);
    dcs_master dcs_master_inst (.clock(clock), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata),
        .ref_we(ref_we), .ref_wdata(ref_wdata));

    always #10 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    // gating: input only, bus only, and, or
    function automatic logic g(input logic [1:0] s, input logic b, input logic d);
        return s == DCS_GATE_DIN ? d : s == DCS_GATE_BUS ? b : s == DCS_GATE_AND ? b & d : b | d;
    endfunction
    task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
        num_checks++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, ex, got);
        end
    endtask
    task automatic rnd();
        {coast_sel, start_sel, setup_sel, preset_sel, reverse_sel, din_setup,
         din_preset} <= 14'($urandom);
        {din_coast_n, din_start, din_reverse, relay1_follow, relay4_follow,
         multi_setup} <= 6'($urandom);
        din_stop_req <= ($urandom % 5) == 0;
        {ctrl_ready, drive_ready, tripped, err_no_trip, trip_locked, warning, on_reference,
         local_mode, freq_in_limit, freq_nonzero, overtemp_auto, dc_volt_bad, torque_over,
         thermal_over} <= 14'($urandom);
        link_ok <= ($urandom % 6) != 0;
        act_value <= 16'($urandom);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(61614));
        cw = CMD_RESET_VAL;
        rnd();
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clock);
            rnd();
            w = 16'($urandom);
            r = 16'($urandom);
            dcs_master_inst.send_ref(r);
            dcs_master_inst.send_cmd(w, i % 3);
            tr = w[10] & w[7] & !cw[7];
            cw = w[10] ? w : cw;
            @(posedge clock);
            #1;
            chk("trip_reset", {15'h0, tr}, {15'h0, trip_reset});
            cg = g(coast_sel, cw[3], din_coast_n);
            sg = g(start_sel, cw[6], din_start);
            // Frozen drive keeps running unless coast, ramp stop, brake or input stop
            rp = cg & sg & cw[2] & (!cw[5] | cw[4]) & !din_stop_req;
            e = {2'h0, !cw[4], rp, g(preset_sel, cw[1], din_preset[1]),
                 g(preset_sel, cw[0], din_preset[0]),
                 multi_setup & g(setup_sel, cw[14], din_setup[1]),
                 multi_setup & g(setup_sel, cw[13], din_setup[0]), !cw[2] | din_stop_req,
                 !cg, !cw[5], cw[9:8], cw[11] & relay1_follow,
                 cw[12] & relay4_follow, g(reverse_sel, cw[15], din_reverse)};
            chk("decode", e, {2'h0, quick_stop, run_permit, preset_idx, setup_idx, dc_brake,
                output_off, freeze, ramp2, jog, relay1, relay4,
                reverse});
            @(posedge clock);
            #1;
            chk("trip_hold", 16'h0000, {15'h0, trip_reset});
            e = {thermal_over, torque_over, dc_volt_bad, overtemp_auto, rp | freq_nonzero,
                 freq_in_limit, !local_mode, on_reference, warning, trip_locked, 1'b0,
                 err_no_trip, tripped, cg, drive_ready, ctrl_ready};
            e = link_ok ? e : 16'h0000;
            chk("status", e, status_word);
            chk("actual_out", act_value, actual_out);
            chk("speed_ref", r, speed_ref);
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule
`default_nettype wire
